// ---- design/bcd_pkg.sv ----
/*
  bcd_pkg: constants shared by the cascaded decade tuning counter.
  assumes a single synchronous clock domain and nothing else.
*/
package bcd_pkg;
  localparam int          BCD_DIGIT_W  = 4;
  localparam logic [3:0]  BCD_MIN      = 4'h0;
  localparam logic [3:0]  BCD_MAX      = 4'h9;
  localparam logic [3:0]  BCD_RST      = 4'h0;
  localparam int          BCD_FREQ_N   = 7;
  localparam int          BCD_OFS_N    = 2;
endpackage

// ---- design/bcd_tuning_counter.sv ----
/*
  bcd_tuning_counter: seven-digit frequency chain and two-digit beat
  oscillator offset chain of cascaded presettable bcd up/down stages.
  assumes tuning controls are synchronous to clk; clock edges are
  qualified by count_pulse so the shared clock runs free.
*/
module bcd_tuning_counter
  import bcd_pkg::*;
#(
  parameter int FREQ_N = BCD_FREQ_N,
  parameter int OFS_N  = BCD_OFS_N
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // frequency chain controls
  input  wire logic                          freq_count_pulse,
  input  wire logic                          freq_up,
  input  wire logic                          freq_preset_en,
  input  wire logic                          freq_carry_in_n,
  input  wire logic [FREQ_N*BCD_DIGIT_W-1:0] freq_preset,
  // offset chain controls
  input  wire logic                          ofs_count_pulse,
  input  wire logic                          ofs_up,
  input  wire logic                          ofs_preset_en,
  input  wire logic                          ofs_carry_in_n,
  input  wire logic [OFS_N*BCD_DIGIT_W-1:0]  ofs_preset,
  // digit and carry outputs
  output logic      [FREQ_N*BCD_DIGIT_W-1:0] frequency_digit_stages,
  output logic      [FREQ_N*BCD_DIGIT_W-1:0] display_driver_digits,
  output logic      [FREQ_N*BCD_DIGIT_W-1:0] synth_digits,
  output logic                               freq_carry_out_n,
  output logic      [BCD_DIGIT_W-1:0]        offset_low_digit_stage,
  output logic      [BCD_DIGIT_W-1:0]        offset_high_digit_stage,
  output logic                               ofs_carry_out_n
);

  // shorter chains leave the ripple checks without an upper digit
  // offset outputs expose only the lowest and highest digit
  if (FREQ_N < 2 || OFS_N < 2) begin : g_bad_size
    $error("chain lengths must be at least two");
  end

  // ------------------------------------------------------------
  // state and next-state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [FREQ_N-1:0][BCD_DIGIT_W-1:0] freq;
    logic [OFS_N-1:0][BCD_DIGIT_W-1:0]  ofs;
  } bcd_state_t;

  bcd_state_t state_reg;
  bcd_state_t state_next;
  logic [FREQ_N:0] fcin_n;
  logic [OFS_N:0]  ocin_n;
  logic [FREQ_N-1:0] fcarry;
  logic [OFS_N-1:0]  ocarry;

  // one decade stage: returns next count
  function automatic logic [3:0] step(input logic [3:0] q,
                                      input logic       up);
    logic [3:0] r;
    r = q;
    if (up) begin
      r = (q >= BCD_MAX) ? BCD_MIN : q + 4'h1;
    end else begin
      r = (q == BCD_MIN || q > BCD_MAX) ? BCD_MAX : q - 4'h1;
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // ripple carry chains
  // ------------------------------------------------------------
  always_comb begin
    fcin_n[0] = freq_carry_in_n;
    for (int i = 0; i < FREQ_N; i++) begin
      fcarry[i] = freq_up ? (state_reg.freq[i] == BCD_MAX)
                          : (state_reg.freq[i] == BCD_MIN);
      fcin_n[i+1] = fcin_n[i] | ~fcarry[i];
    end
    ocin_n[0] = ofs_carry_in_n;
    for (int j = 0; j < OFS_N; j++) begin
      ocarry[j] = ofs_up ? (state_reg.ofs[j] == BCD_MAX)
                         : (state_reg.ofs[j] == BCD_MIN);
      ocin_n[j+1] = ocin_n[j] | ~ocarry[j];
    end
  end

  // ------------------------------------------------------------
  // next count
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < FREQ_N; i++) begin
      if (freq_preset_en) begin
        // preset overrides counting; load rather than merely hold
        state_next.freq[i] = freq_preset[i*BCD_DIGIT_W +: BCD_DIGIT_W];
      end else if (freq_count_pulse && !fcin_n[i]) begin
        state_next.freq[i] = step(state_reg.freq[i], freq_up);
      end
    end
    for (int j = 0; j < OFS_N; j++) begin
      if (ofs_preset_en) begin
        state_next.ofs[j] = ofs_preset[j*BCD_DIGIT_W +: BCD_DIGIT_W];
      end else if (ofs_count_pulse && !ocin_n[j]) begin
        state_next.ofs[j] = step(state_reg.ofs[j], ofs_up);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < FREQ_N; i++) begin
        state_reg.freq[i] <= BCD_RST;
      end
      for (int j = 0; j < OFS_N; j++) begin
        state_reg.ofs[j] <= BCD_RST;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign frequency_digit_stages  = state_reg.freq;
  assign display_driver_digits   = state_reg.freq;
  assign synth_digits            = state_reg.freq;
  assign freq_carry_out_n        = fcin_n[FREQ_N];
  assign offset_low_digit_stage  = state_reg.ofs[0];
  assign offset_high_digit_stage = state_reg.ofs[OFS_N-1];
  assign ofs_carry_out_n         = ocin_n[OFS_N];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_up_step: assert property (@(posedge clk) disable iff (!nrst)
    freq_count_pulse && freq_up && !freq_preset_en && !freq_carry_in_n
    && state_reg.freq[0] < BCD_MAX |=>
    state_reg.freq[0] == $past(state_reg.freq[0]) + 4'h1)
    else $error("low digit did not count up");
  a_down_step: assert property (@(posedge clk) disable iff (!nrst)
    freq_count_pulse && !freq_up && !freq_preset_en && !freq_carry_in_n
    && state_reg.freq[0] > BCD_MIN && state_reg.freq[0] <= BCD_MAX |=>
    state_reg.freq[0] == $past(state_reg.freq[0]) - 4'h1)
    else $error("low digit did not count down");
  a_preset_load: assert property (@(posedge clk) disable iff (!nrst)
    freq_preset_en |=> state_reg.freq == $past(freq_preset))
    else $error("preset not loaded");
  a_cin_hold: assert property (@(posedge clk) disable iff (!nrst)
    freq_carry_in_n && !freq_preset_en |=> $stable(state_reg.freq))
    else $error("stage moved with carry-in high");
  a_cout_level: assert property (@(posedge clk) disable iff (!nrst)
    !freq_carry_out_n |-> !freq_carry_in_n && (&fcarry))
    else $error("carry-out low outside carry");
  a_wrap_up: assert property (@(posedge clk) disable iff (!nrst)
    ofs_count_pulse && ofs_up && !ofs_preset_en && !ofs_carry_in_n
    && state_reg.ofs[0] == BCD_MAX |=> state_reg.ofs[0] == BCD_MIN)
    else $error("offset digit did not wrap 9 to 0");
  a_ripple_hold: assert property (@(posedge clk) disable iff (!nrst)
    !freq_preset_en && !fcarry[0] |=>
    state_reg.freq[FREQ_N-1:1] == $past(state_reg.freq[FREQ_N-1:1]))
    else $error("upper stage moved without carry");
  a_bcd_range: assert property (@(posedge clk) disable iff (!nrst)
    !$past(freq_preset_en) && $past(state_reg.freq[0]) <= BCD_MAX
    |-> state_reg.freq[0] <= BCD_MAX)
    else $error("digit left bcd range");
  a_out_match: assert property (@(posedge clk) disable iff (!nrst)
    synth_digits == display_driver_digits)
    else $error("display and synthesizer digits differ");
  // carry level judged from the digits, not from the ripple terms
  a_ofs_cout: assert property (@(posedge clk) disable iff (!nrst)
    !ofs_carry_out_n == (!ofs_carry_in_n && (ofs_up
      ? state_reg.ofs == {OFS_N{BCD_MAX}}
      : state_reg.ofs == {OFS_N{BCD_MIN}})))
    else $error("offset carry-out level wrong");
  a_ofs_cin_hold: assert property (@(posedge clk) disable iff (!nrst)
    ofs_carry_in_n && !ofs_preset_en |=> $stable(state_reg.ofs))
    else $error("offset stage moved with carry-in high");
  a_ofs_preset: assert property (@(posedge clk) disable iff (!nrst)
    ofs_preset_en |=> state_reg.ofs == $past(ofs_preset))
    else $error("offset preset not loaded");
  a_down_wrap: assert property (@(posedge clk) disable iff (!nrst)
    freq_count_pulse && !freq_up && !freq_preset_en && !freq_carry_in_n
    && state_reg.freq[0] == BCD_MIN |=> state_reg.freq[0] == BCD_MAX)
    else $error("low digit did not wrap 0 to 9");
  a_ripple_step: assert property (@(posedge clk) disable iff (!nrst)
    freq_count_pulse && freq_up && !freq_preset_en && !freq_carry_in_n
    && state_reg.freq[0] == BCD_MAX && state_reg.freq[1] < BCD_MAX
    |=> state_reg.freq[1] == $past(state_reg.freq[1]) + 4'h1)
    else $error("second digit missed the ripple carry");
  a_freq_chain: assert property (@(posedge clk) disable iff (!nrst)
    freq_count_pulse && freq_up && !freq_preset_en && !freq_carry_in_n
    && state_reg.freq == {FREQ_N{BCD_MAX}}
    |=> state_reg.freq == {FREQ_N{BCD_MIN}})
    else $error("full chain did not roll over");
  a_ofs_chain: assert property (@(posedge clk) disable iff (!nrst)
    ofs_count_pulse && !ofs_up && !ofs_preset_en && !ofs_carry_in_n
    && state_reg.ofs == {OFS_N{BCD_MIN}}
    |=> state_reg.ofs == {OFS_N{BCD_MAX}})
    else $error("offset chain did not roll under");

  c_up_wrap: cover property (@(posedge clk) disable iff (!nrst)
    freq_count_pulse && freq_up && !freq_carry_out_n);
  c_down_wrap: cover property (@(posedge clk) disable iff (!nrst)
    ofs_count_pulse && !ofs_up && !ofs_carry_out_n);
  c_preset: cover property (@(posedge clk) disable iff (!nrst)
    freq_preset_en ##1 freq_count_pulse);
  c_ofs_preset: cover property (@(posedge clk) disable iff (!nrst)
    ofs_preset_en ##1 ofs_count_pulse);
  c_cin_block: cover property (@(posedge clk) disable iff (!nrst)
    freq_carry_in_n && freq_count_pulse);

endmodule

// ---- tb/bcd_panel_model.sv ----
/*
  tuning panel model: count pulses and direction level.
  assumes the counter samples on rising clk.
*/
module bcd_panel_model (
  input  wire logic clk,
  output logic      pulse,
  output logic      up
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pulse = 1'b0;
    up = 1'b1;
  end
  // n taken edges; pulse drops after the last
  task tune(input logic dir, input int n);
    @(posedge clk);
    pulse <= 1'b1;
    up    <= dir;
    repeat (n) @(posedge clk);
    pulse <= 1'b0;
    #1;
  endtask
endmodule

// ---- tb/bcd_tuning_counter_tb.sv ----
/*
  self-checking bench for the tuning counter chains.
  assumes one 20 MHz clock; panel models drive the counts.
*/
module bcd_tuning_counter_tb;
  import bcd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, nrst, fp, fu, fpe, fci, op, ou, ope, oci;
  logic        fco, oco;
  logic [27:0] fpr, fd, dd, sd;
  logic [7:0]  opr;
  logic [3:0]  ol, oh;
  int          err_count = 0;
  int          n_tests = 0;
  bcd_panel_model pf (.clk(clk), .pulse(fp), .up(fu));
  bcd_panel_model po (.clk(clk), .pulse(op), .up(ou));
  bcd_tuning_counter uut (
    .clk(clk), .nrst(nrst), .freq_count_pulse(fp), .freq_up(fu),
    .freq_preset_en(fpe), .freq_carry_in_n(fci), .freq_preset(fpr),
    .ofs_count_pulse(op), .ofs_up(ou), .ofs_preset_en(ope),
    .ofs_carry_in_n(oci), .ofs_preset(opr),
    .frequency_digit_stages(fd), .display_driver_digits(dd),
    .synth_digits(sd), .freq_carry_out_n(fco),
    .offset_low_digit_stage(ol), .offset_high_digit_stage(oh),
    .ofs_carry_out_n(oco));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task print_verdict;
    $display("mismatches %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [27:0] got, input logic [27:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // all three digit copies must agree
  task chkf(input logic [27:0] e, input logic co);
    chk(fd, e);
    chk(dd, e);
    chk(sd, e);
    chk({27'h0, fco}, {27'h0, co});
  endtask
  task pre(input logic [27:0] v);
    @(posedge clk);
    fpr <= v;
    fpe <= 1'b1;
    @(posedge clk);
    fpe <= 1'b0;
    #1;
  endtask
  task t_up;
    pre(28'h0999998);
    pf.tune(1'b1, 1);
    chkf(28'h0999999, 1'b1);
    pf.tune(1'b1, 1);
    chkf(28'h1000000, 1'b1);
    pre(28'h9999999);
    chkf(28'h9999999, 1'b0);
    pf.tune(1'b1, 1);
    chkf(28'h0000000, 1'b1);
  endtask
  task t_down;
    pf.tune(1'b0, 2);
    chkf(28'h9999998, 1'b1);
    pre(28'h1000000);
    pf.tune(1'b0, 1);
    chkf(28'h0999999, 1'b1);
    pre(28'h0000000);
    chkf(28'h0000000, 1'b0);
  endtask
  // preset held and carry-in high must both freeze counting
  task t_hold;
    @(posedge clk);
    fpr <= 28'h0000123;
    fpe <= 1'b1;
    pf.tune(1'b1, 3);
    chkf(28'h0000123, 1'b1);
    @(posedge clk);
    fpe <= 1'b0;
    fci <= 1'b1;
    pf.tune(1'b1, 4);
    chkf(28'h0000123, 1'b1);
    @(posedge clk);
    fci <= 1'b0;
  endtask
  task t_ofs;
    @(posedge clk);
    opr <= 8'h98;
    ope <= 1'b1;
    @(posedge clk);
    ope <= 1'b0;
    po.tune(1'b1, 2);
    chk({19'h0, oco, oh, ol}, {19'h0, 1'b1, 8'h00});
    po.tune(1'b0, 1);
    chk({19'h0, oco, oh, ol}, {19'h0, 1'b1, 8'h99});
    @(posedge clk);
    opr <= 8'h00;
    ope <= 1'b1;
    @(posedge clk);
    ope <= 1'b0;
    #1;
    chk({19'h0, oco, oh, ol}, {19'h0, 1'b0, 8'h00});
    @(posedge clk);
    oci <= 1'b1;
    po.tune(1'b0, 2);
    chk({19'h0, oco, oh, ol}, {19'h0, 1'b1, 8'h00});
    @(posedge clk);
    oci <= 1'b0;
  endtask
  // mid-run reset clears both chains; counting resumes after release
  task t_reset;
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    #1;
    chkf(28'h0000000, 1'b1);
    chk({19'h0, oco, oh, ol}, {19'h0, 1'b1, 8'h00});
    @(posedge clk);
    nrst <= 1'b1;
    pf.tune(1'b1, 1);
    chkf(28'h0000001, 1'b1);
    pre(28'h0000019);
    pf.tune(1'b1, 1);
    chkf(28'h0000020, 1'b1);
  endtask
  // codes above nine recover in one count
  task t_bad;
    pre(28'h000000C);
    pf.tune(1'b1, 1);
    chkf(28'h0000000, 1'b1);
    pre(28'h000000C);
    pf.tune(1'b0, 1);
    chkf(28'h0000009, 1'b1);
  endtask
  initial begin
    {nrst, fpe, fci, ope, oci} = 5'h00;
    fpr = 28'h0000000;
    opr = 8'h00;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chkf(28'h0000000, 1'b1);
    t_up();
    t_down();
    t_hold();
    t_reset();
    t_ofs();
    t_bad();
    print_verdict();
  end
endmodule
